// ### rtl/rsg_consts.vh
// Constants for the RAM guard, register guard and invalid access detector.
// Assumes a 20-bit byte address space and 8-bit data on the CPU bus.
`ifndef RSG_CONSTS_VH
`define RSG_CONSTS_VH

// Bus widths
`define RSG_ADDR_W          20
`define RSG_DATA_W          8

// Own register addresses and reset values
`define RSG_GUARD_CTL_ADDR  20'hF_0078
`define RSG_RAM_BASE_ADDR   20'hF_F076
`define RSG_GUARD_CTL_RST   8'h00
`define RSG_RAM_BASE_RST    8'hEF

// guard_control field positions
`define RSG_IAE_BIT         7
`define RSG_SIZE_HI         5
`define RSG_SIZE_LO         4
`define RSG_PORT_BIT        2
`define RSG_INT_BIT         1
`define RSG_CLKV_BIT        0

// ram_base_page legal range and address forming
`define RSG_PAGE_MIN        8'h9F
`define RSG_PAGE_MAX        8'hFD
`define RSG_RAM_TOP         4'hF
`define RSG_PAGE_LOW        8'h00

// Software must keep off RAM this many clocks after a base page write
`define RSG_BASE_SETTLE_CLKS 2

// Guard window lengths in bytes, one wider than the address
`define RSG_WIN_128         21'h0_0080
`define RSG_WIN_256         21'h0_0100
`define RSG_WIN_512         21'h0_0200

// Memory map boundaries of the two variants
`define RSG_CODE_END_L      20'h3_FFFF
`define RSG_CODE_END_S      20'h1_FFFF
`define RSG_MIRROR_L        20'hF_5000
`define RSG_MIRROR_S        20'hF_3000
`define RSG_DFLASH_START    20'hF_1000

// Special register groups covered by the register guard
`define RSG_PORT_LO         20'hF_0030
`define RSG_PORT_HI         20'hF_006F
`define RSG_PDATA_LO        20'hF_FF00
`define RSG_PDATA_HI        20'hF_FF1F
`define RSG_INT_LO          20'hF_FFD0
`define RSG_INT_HI          20'hF_FFEF
`define RSG_CLKV_LO         20'hF_00F0
`define RSG_CLKV_HI         20'hF_00FF
`define RSG_CONV_CKS_ADDR   20'hF_00F8

`endif

// ### rtl/rsg_addr_decode.v
// Address classifier for the guard block: RAM guard window, special
// register groups and forbidden spaces. Purely combinational.
// Assumes the RAM start page is already a legal, settled value.
`timescale 1ns/10ps
`default_nettype none
`include "rsg_consts.vh"

module rsg_addr_decode #(
  parameter LARGE_VARIANT = 1
) (
  input  wire [`RSG_ADDR_W-1:0] addr_i,
  input  wire [7:0]             ram_page_i,
  input  wire [1:0]             ram_guard_size_i,
  output reg                    in_ram_guard_o,
  output reg                    in_port_grp_o,
  output reg                    in_int_grp_o,
  output reg                    in_clkv_grp_o,
  output reg                    is_conv_cks_o,
  output reg                    in_gap_o,
  output reg                    in_mirror_o
);

  ////////////////////////////////////////////////////////////////////////
  // Memory map boundaries chosen by the variant
  wire [`RSG_ADDR_W-1:0] code_end   = LARGE_VARIANT ? `RSG_CODE_END_L : `RSG_CODE_END_S;
  wire [`RSG_ADDR_W-1:0] code_after = code_end + 20'h0_0001;
  wire [`RSG_ADDR_W-1:0] mirror_lo  = LARGE_VARIANT ? `RSG_MIRROR_L : `RSG_MIRROR_S;
  wire [`RSG_ADDR_W-1:0] ram_start  = {`RSG_RAM_TOP, ram_page_i, `RSG_PAGE_LOW};
  reg  [`RSG_ADDR_W:0]   win_len;
  wire [`RSG_ADDR_W:0]   win_end    = {1'b0, ram_start} + win_len;

  ////////////////////////////////////////////////////////////////////////
  // Window length from the size field, zero means no protection
  always @* begin
    case (ram_guard_size_i)
      2'b01:   win_len = `RSG_WIN_128;
      2'b10:   win_len = `RSG_WIN_256;
      2'b11:   win_len = `RSG_WIN_512;
      default: win_len = {(`RSG_ADDR_W+1){1'b0}};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Range compares; the window end is one wider so it cannot wrap
  always @* begin
    in_ram_guard_o = (ram_guard_size_i != 2'b00) && (addr_i >= ram_start)
                     && ({1'b0, addr_i} < win_end);
    // Port output data sits outside the port group on purpose
    in_port_grp_o  = (addr_i >= `RSG_PORT_LO) && (addr_i <= `RSG_PORT_HI)
                     && !((addr_i >= `RSG_PDATA_LO) && (addr_i <= `RSG_PDATA_HI));
    in_int_grp_o   = (addr_i >= `RSG_INT_LO) && (addr_i <= `RSG_INT_HI);
    in_clkv_grp_o  = (addr_i >= `RSG_CLKV_LO) && (addr_i <= `RSG_CLKV_HI);
    is_conv_cks_o  = (addr_i == `RSG_CONV_CKS_ADDR);
    // Unimplemented gap between code flash end and data flash
    in_gap_o       = (addr_i >= code_after) && (addr_i < `RSG_DFLASH_START);
    // Mirror runs up to one below the RAM start
    in_mirror_o    = (addr_i >= mirror_lo) && (addr_i < ram_start);
  end

endmodule
`default_nettype wire

// ### rtl/rsg_guard.v
// RAM guard, special register guard and invalid memory access detector
// sitting between the CPU core and the memories / special registers.
// Assumes a CPU bus with single-cycle strobes, no wait states, and
// all inputs from logic on the same clock.
// Own registers answer on a registered read-back port one cycle after
// the read strobe and are never passed on to memory or other registers.
// Forwarded strobes are combinational and only ever masked, never held
// back, so a blocked access costs the CPU no extra cycles.
// The internal reset request is a one-cycle pulse; the reset controller
// is expected to stretch it.
`timescale 1ns/10ps
`default_nettype none
`include "rsg_consts.vh"

module rsg_guard #(
  parameter LARGE_VARIANT = 1
) (
  input  wire                   clock_i,
  input  wire                   rst_n_i,
  input  wire [`RSG_ADDR_W-1:0] cpu_addr_i,
  input  wire [`RSG_DATA_W-1:0] cpu_wdata_i,
  input  wire                   cpu_wr_i,
  input  wire                   cpu_rd_i,
  input  wire                   debug_step_i,
  input  wire                   watchdog_option_on_i,
  input  wire                   converter_power_enable_i,
  output wire                   mem_wr_o,
  output wire                   mem_rd_o,
  output wire                   reg_hit_o,
  output reg  [`RSG_DATA_W-1:0] reg_rdata_o,
  output reg                    reg_rvalid_o,
  output reg                    invalid_reset_o,
  output wire [`RSG_ADDR_W-1:0] ram_start_o
);

  ////////////////////////////////////////////////////////////////////////
  // State registers
  // Each register gets its next value from one process further down
  reg        iae_q;        // invalid_access_enable
  reg        iae_d;
  reg  [1:0] size_q;       // ram_guard_size
  reg  [1:0] size_d;
  reg        port_en_q;    // port_guard_enable
  reg        port_en_d;
  reg        int_en_q;     // interrupt_guard_enable
  reg        int_en_d;
  reg        clkv_en_q;    // clock_voltage_guard_enable
  reg        clkv_en_d;
  reg  [7:0] page_q;       // ram_base_page
  reg  [7:0] page_d;
  reg        page_lock_q;  // Set by the one accepted base page write
  reg        page_lock_d;
  reg  [`RSG_DATA_W-1:0] rdata_d;
  reg        rvalid_d;
  reg        inv_rst_d;

  ////////////////////////////////////////////////////////////////////////
  // Address classification
  // Map as classified here, large variant first and small second:
  //   code flash   00000H up to the variant's code end
  //   gap          code end + 1 up to F0FFFH, no access allowed
  //   data flash   F1000H up to one below the mirror start
  //   mirror       F5000H or F3000H up to one below the RAM start
  //   RAM          RAM start up to FFEFFH, guard window at its bottom
  // The mirror end follows the base page, so it moves with that write.
  wire in_ram_guard;
  wire in_port_grp;
  wire in_int_grp;
  wire in_clkv_grp;
  wire is_conv_cks;
  wire in_gap;
  wire in_mirror;

  rsg_addr_decode #(
    .LARGE_VARIANT (LARGE_VARIANT)
  ) u_decode (
    .addr_i           (cpu_addr_i),
    .ram_page_i       (page_q),
    .ram_guard_size_i (size_q),
    .in_ram_guard_o   (in_ram_guard),
    .in_port_grp_o    (in_port_grp),
    .in_int_grp_o     (in_int_grp),
    .in_clkv_grp_o    (in_clkv_grp),
    .is_conv_cks_o    (is_conv_cks),
    .in_gap_o         (in_gap),
    .in_mirror_o      (in_mirror)
  );

  ////////////////////////////////////////////////////////////////////////
  // Own register decode, if and else-if style. The two addresses never
  // both match, so the priority here is only a matter of form.
  reg hit_ctl;
  reg hit_base;

  always @* begin
    hit_ctl  = 1'b0;
    hit_base = 1'b0;
    if (cpu_addr_i == `RSG_GUARD_CTL_ADDR) begin
      hit_ctl = 1'b1;
    end else if (cpu_addr_i == `RSG_RAM_BASE_ADDR) begin
      hit_base = 1'b1;
    end
  end

  wire own_hit = hit_ctl | hit_base;
  assign reg_hit_o = own_hit & (cpu_wr_i | cpu_rd_i);

  ////////////////////////////////////////////////////////////////////////
  // Write blocking. A blocked write just never reaches the target; the
  // CPU sees a normal completion because there is no wait or error path.
  wire ram_block  = in_ram_guard & ~debug_step_i;
  // One lane per guarded group, in the bit order of guard_control
  wire [2:0] grp_hit = {in_port_grp, in_int_grp, in_clkv_grp};
  wire [2:0] grp_en  = {port_en_q, int_en_q, clkv_en_q};
  wire [2:0] grp_block;
  genvar     gi;

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_grp
      // A set group bit masks writes only; reads of the group stay open
      assign grp_block[gi] = grp_hit[gi] & grp_en[gi];
    end
  endgenerate

  wire port_block = grp_block[`RSG_PORT_BIT];
  wire int_block  = grp_block[`RSG_INT_BIT];
  wire clkv_block = grp_block[`RSG_CLKV_BIT];
  // Converter clock select is dark in both directions while unpowered
  wire conv_off   = is_conv_cks & ~converter_power_enable_i;
  wire wr_block   = ram_block | port_block | int_block | clkv_block | conv_off;

  // Reads are never stopped by a guard bit, only by the converter gate and the own register decode
  assign mem_wr_o = cpu_wr_i & ~own_hit & ~wr_block;
  assign mem_rd_o = cpu_rd_i & ~own_hit & ~conv_off;

  ////////////////////////////////////////////////////////////////////////
  // RAM start as seen by the rest of the chip
  assign ram_start_o = {`RSG_RAM_TOP, page_q, `RSG_PAGE_LOW};

  ////////////////////////////////////////////////////////////////////////
  // Limitations worth knowing before reuse:
  //   Only byte strobes are understood; a wider access must arrive as
  //   separate byte strobes or its upper bytes escape the compares.
  //   The base page lock and the sticky enable clear only on rst_n_i,
  //   so a soft reset that bypasses rst_n_i leaves both as they were.
  //   A blocked write completes like any other; software only sees the
  //   block by reading the target back.

  ////////////////////////////////////////////////////////////////////////
  // Strobes qualified by the own register decode
  wire ctl_wr  = cpu_wr_i & hit_ctl;
  wire ctl_rd  = cpu_rd_i & hit_ctl;
  wire base_wr = cpu_wr_i & hit_base;
  wire base_rd = cpu_rd_i & hit_base;

  // An out-of-range page is dropped without using up the single write
  wire page_legal = (cpu_wdata_i >= `RSG_PAGE_MIN) && (cpu_wdata_i <= `RSG_PAGE_MAX);
  wire page_take  = base_wr & ~page_lock_q & page_legal;

  ////////////////////////////////////////////////////////////////////////
  // Guard control next state
  always @* begin
    iae_d     = iae_q;
    size_d    = size_q;
    port_en_d = port_en_q;
    int_en_d  = int_en_q;
    clkv_en_d = clkv_en_q;
    if (ctl_wr) begin
      // Enable only ever sets; a written zero leaves it as it was
      iae_d     = iae_q | cpu_wdata_i[`RSG_IAE_BIT];
      size_d    = cpu_wdata_i[`RSG_SIZE_HI:`RSG_SIZE_LO];
      port_en_d = cpu_wdata_i[`RSG_PORT_BIT];
      int_en_d  = cpu_wdata_i[`RSG_INT_BIT];
      clkv_en_d = cpu_wdata_i[`RSG_CLKV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Base page next state; the lock is what makes it write-once
  always @* begin
    page_d      = page_q;
    page_lock_d = page_lock_q;
    if (page_take) begin
      page_d      = cpu_wdata_i;
      page_lock_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, presented one cycle after the read strobe
  always @* begin
    rdata_d  = {`RSG_DATA_W{1'b0}};
    rvalid_d = ctl_rd | base_rd;
    if (ctl_rd) begin
      // Bits 6 and 3 are reserved and read as zero
      rdata_d[`RSG_IAE_BIT]                 = iae_q;
      rdata_d[`RSG_SIZE_HI:`RSG_SIZE_LO]    = size_q;
      rdata_d[`RSG_PORT_BIT]                = port_en_q;
      rdata_d[`RSG_INT_BIT]                 = int_en_q;
      rdata_d[`RSG_CLKV_BIT]                = clkv_en_q;
    end else if (base_rd) begin
      rdata_d = page_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Invalid access detection. The option strap overrides a cleared
  // enable, so a runaway that never set the bit is still caught.
  wire det_en    = iae_q | watchdog_option_on_i;
  wire any_acc   = cpu_wr_i | cpu_rd_i;
  // Gap is forbidden for any access, the mirror only for writes, so
  // constants placed in the mirror can still be read
  wire gap_hit    = in_gap & any_acc;
  wire mirror_hit = in_mirror & cpu_wr_i;
  wire forbidden  = gap_hit | mirror_hit;

  always @* begin
    inv_rst_d = det_en & forbidden;
  end

  ////////////////////////////////////////////////////////////////////////
  // Guard control flip-flops; all guard bits come back cleared after
  // reset, so no group is locked while start-up code runs
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iae_q     <= 1'b0;
      size_q    <= 2'b00;
      port_en_q <= 1'b0;
      int_en_q  <= 1'b0;
      clkv_en_q <= 1'b0;
    end else begin
      iae_q     <= iae_d;
      size_q    <= size_d;
      port_en_q <= port_en_d;
      int_en_q  <= int_en_d;
      clkv_en_q <= clkv_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Base page flip-flops. The lock only clears on reset, which is what
  // keeps a runaway from moving the window after start-up.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_q      <= `RSG_RAM_BASE_RST;
      page_lock_q <= 1'b0;
    end else begin
      page_q      <= page_d;
      page_lock_q <= page_lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read return flip-flops; data is zero whenever valid is low
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o  <= {`RSG_DATA_W{1'b0}};
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= rdata_d;
      reg_rvalid_o <= rvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset request flip-flop; registered so the request is glitch free
  // even though the address compares in front of it are wide
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      invalid_reset_o <= 1'b0;
    end else begin
      invalid_reset_o <= inv_rst_d;
    end
  end

endmodule
`default_nettype wire

// ### verification/rsg_guard_asserts.sv
// Port-level checker for the guard block.
// Assumes one clock domain and the shared constants header.
`timescale 1ns/10ps
`default_nettype none
`include "rsg_consts.vh"
module rsg_guard_asserts #(parameter LARGE_VARIANT = 1) (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic [19:0] cpu_addr_i,
  input wire logic        cpu_wr_i,
  input wire logic        cpu_rd_i,
  input wire logic        debug_step_i,
  input wire logic        watchdog_option_on_i,
  input wire logic        mem_wr_o,
  input wire logic        mem_rd_o,
  input wire logic        reg_hit_o,
  input wire logic        reg_rvalid_o,
  input wire logic        invalid_reset_o,
  input wire logic [19:0] ram_start_o
);
  localparam logic [19:0] GAP_LO = LARGE_VARIANT ? 20'h4_0000 : 20'h2_0000;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Forced detection and a strobe into the flash gap
  sequence s_gap;
    watchdog_option_on_i && (cpu_rd_i || cpu_wr_i) && cpu_addr_i >= GAP_LO && cpu_addr_i < `RSG_DFLASH_START;
  endsequence
  sequence s_own_rd;
    reg_hit_o && cpu_rd_i;
  endsequence
  AST_OWN_RD: assert property (s_own_rd |=> reg_rvalid_o)
    else $error("own read gave no valid");
  AST_WR_CAUSE: assert property (mem_wr_o |-> cpu_wr_i)
    else $error("write forwarded without strobe");
  AST_RD_CAUSE: assert property (mem_rd_o |-> cpu_rd_i)
    else $error("read forwarded without strobe");
  AST_DEBUG: assert property (debug_step_i && cpu_wr_i && cpu_addr_i >= ram_start_o
    && cpu_addr_i <= 20'hF_FEFF && !reg_hit_o |-> mem_wr_o) else $error("debug write blocked");
  AST_ABOVE: assert property (cpu_wr_i && cpu_addr_i >= ram_start_o + 20'h0_0200
    && cpu_addr_i <= 20'hF_FEFF && !reg_hit_o |-> mem_wr_o) else $error("write above window blocked");
  AST_OWN_HIT: assert property ((cpu_wr_i || cpu_rd_i) && (cpu_addr_i == `RSG_GUARD_CTL_ADDR
    || cpu_addr_i == `RSG_RAM_BASE_ADDR) |-> reg_hit_o && !mem_wr_o && !mem_rd_o)
    else $error("own register access not kept inside");
  AST_PDATA: assert property (cpu_wr_i && cpu_addr_i[19:5] == 15'h7FF8 |-> mem_wr_o)
    else $error("port data write blocked");
  AST_WDT: assert property (s_gap |=> invalid_reset_o)
    else $error("forced detection missed");
  AST_INV_CAUSE: assert property (invalid_reset_o |-> $past(cpu_rd_i) || $past(cpu_wr_i))
    else $error("reset request without access");
  AST_BASE_HOLD: assert property (!(reg_hit_o && cpu_wr_i) |=> $stable(ram_start_o))
    else $error("ram start moved without write");
  AST_START_FORM: assert property (ram_start_o[19:16] == 4'hF && ram_start_o[7:0] == 8'h00
    && ram_start_o[15:8] >= 8'h9F && ram_start_o[15:8] <= 8'hFD) else $error("ram start malformed");
endmodule
bind rsg_guard rsg_guard_asserts #(.LARGE_VARIANT(LARGE_VARIANT)) u_asserts (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
  .debug_step_i(debug_step_i), .watchdog_option_on_i(watchdog_option_on_i), .mem_wr_o(mem_wr_o),
  .mem_rd_o(mem_rd_o), .reg_hit_o(reg_hit_o), .reg_rvalid_o(reg_rvalid_o),
  .invalid_reset_o(invalid_reset_o), .ram_start_o(ram_start_o));
`default_nettype wire

// ### verification/rsg_cpu_model.sv
// CPU core model issuing one-cycle read and write strobes.
// Assumes forwarding is combinational and own reads answer a cycle later.
`timescale 1ns/10ps
`default_nettype none
`include "rsg_consts.vh"
module rsg_cpu_model (
  input  wire logic        clock_i,
  input  wire logic        mem_wr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        reg_rvalid_i,
  input  wire logic [7:0]  reg_rdata_i,
  output var  logic [19:0] addr_o,
  output var  logic [7:0]  wdata_o,
  output var  logic        wr_o,
  output var  logic        rd_o
);
  initial begin
    addr_o = 20'h0_0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Idle address and data lines show inverted values so stale data is never mistaken
  task automatic acc(input logic w, input logic [19:0] a, input logic [7:0] d,
                     output logic fwd, output logic [7:0] q);
    @(negedge clock_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    #4;
    fwd = w ? mem_wr_i : mem_rd_i;
    @(negedge clock_i);
    q = reg_rvalid_i ? reg_rdata_i : 8'hxx;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    // Keep off RAM while a new base page settles
    if (w && a == `RSG_RAM_BASE_ADDR) repeat (2) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// ### verification/rsg_guard_test.sv
// Self-checking bench for the guard block, driven through the CPU model.
// Assumes the large memory map variant.
`timescale 1ns/10ps
`default_nettype none
`include "rsg_consts.vh"
module rsg_guard_test;
  localparam logic [19:0] GC = `RSG_GUARD_CTL_ADDR;
  localparam logic [19:0] BP = `RSG_RAM_BASE_ADDR;
  logic        clock_i = 0, rst_n_i = 0, dbg = 0, wdt = 0, cpe = 0, f;
  logic [7:0]  q, wd, rdata;
  logic [19:0] b, addr, start;
  logic [19:0] grp [3] = '{20'hF_00F0, 20'hF_FFD0, 20'hF_0030};
  wire         wr, rd, mwr, mrd, rv, inv;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  rsg_guard #(.LARGE_VARIANT(1)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_addr_i(addr),
    .cpu_wdata_i(wd), .cpu_wr_i(wr), .cpu_rd_i(rd), .debug_step_i(dbg), .watchdog_option_on_i(wdt),
    .converter_power_enable_i(cpe), .mem_wr_o(mwr), .mem_rd_o(mrd), .reg_hit_o(),
    .reg_rdata_o(rdata), .reg_rvalid_o(rv), .invalid_reset_o(inv), .ram_start_o(start));
  rsg_cpu_model u_cpu (.clock_i(clock_i), .mem_wr_i(mwr), .mem_rd_i(mrd), .reg_rvalid_i(rv),
    .reg_rdata_i(rdata), .addr_o(addr), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
  ////////////////////////////////////////////////////////////////////////////
  always #5 clock_i = ~clock_i;
  // Cut a hang short well above the expected run length
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input string s, input logic [19:0] g, input logic [19:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wrt(input logic [19:0] a, input logic [7:0] d);
    u_cpu.acc(1'b1, a, d, f, q);
  endtask
  task automatic rdt(input logic [19:0] a);
    u_cpu.acc(1'b0, a, 8'h00, f, q);
  endtask
  task automatic finish_test;
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock_i);
    @(negedge clock_i) rst_n_i = 1;
    rdt(GC); chk("guard_control", q, 8'h00);
    rdt(BP); chk("ram_base_page", q, 8'hEF);
    wrt(20'hF_EF00, 8'h5A); chk("unguarded ram", f, 1);
    wrt(BP, 8'hFE); rdt(BP); chk("base range", q, 8'hEF);
    wrt(BP, 8'h9F);
    wrt(BP, 8'hCF); rdt(BP); chk("base once", q, 8'h9F);
    chk("ram_start", start, 20'hF_9F00);
    // Window sizes; nothing here uses the window as stack
    for (int s = 1; s < 4; s++) begin
      b = 20'h0_0040 << s;
      wrt(GC, 8'(s << 4)); rdt(GC); chk("size", q, 8'(s << 4));
      wrt(20'hF_9EFF + b, 8'h33); chk("window end", f, 0);
      chk("silent block", inv, 0);
      wrt(20'hF_9F00 + b, 8'h33); chk("past window", f, 1);
      dbg = 1; wrt(20'hF_9F00, 8'h44); dbg = 0; chk("debug step", f, 1);
    end
    // Each guard bit blocks only its own group, reads stay open
    for (int g = 0; g < 3; g++) begin
      wrt(GC, 8'(1 << g));
      for (int i = 0; i < 3; i++) begin
        wrt(grp[i], 8'h11); chk("group write", f, i != g);
        rdt(grp[i]); chk("group read", f, 1);
      end
    end
    wrt(GC, 8'h07); wrt(20'hF_FF00, 8'h01); chk("port data", f, 1);
    wrt(GC, 8'h00); rdt(`RSG_CONV_CKS_ADDR); chk("conv off", f, 0);
    cpe = 1; wrt(`RSG_CONV_CKS_ADDR, 8'h01); chk("conv on", f, 1);
    rdt(20'h4_0000); chk("detect off", inv, 0);
    wdt = 1; rdt(20'h4_0000); wdt = 0; chk("forced detect", inv, 1);
    wrt(GC, 8'h80); wrt(GC, 8'h00); rdt(GC); chk("sticky enable", q, 8'h80);
    rdt(20'h4_0000); chk("gap access", inv, 1);
    rdt(20'h3_FFFF); chk("flash end", inv, 0);
    wrt(20'hF_5000, 8'h00); chk("mirror write", inv, 1);
    wrt(20'hF_4FFF, 8'h00); chk("data flash", inv, 0);
    // A second reset clears the enable and re-opens the base page
    rst_n_i = 0;
    @(negedge clock_i) rst_n_i = 1;
    rdt(GC); chk("reset again", q, 8'h00);
    wrt(BP, 8'hAF); rdt(BP); chk("base after reset", q, 8'hAF);
    finish_test();
  end
endmodule
`default_nettype wire
